// [block_xfer_map.svh]
// Register offsets, block identifier ranges, limits and timing constants
`ifndef BLOCK_XFER_MAP_SVH
`define BLOCK_XFER_MAP_SVH

`define WBUF_BASE 12'h000
`define WBUF_LAST 12'h0FC
`define CTRL_ADDR 12'h100
`define STATUS_ADDR 12'h104
`define RDHDR_ADDR 12'h108
`define CFGA_ADDR 12'h10C
`define CFGB_ADDR 12'h110

`define STAT_CONFIGURED 0
`define STAT_PORT_ERR 1
`define STAT_SYS_ERR 2
`define STAT_POLL_HELD 3

`define ID_POLL_LO 16'h0050
`define ID_POLL_HI 16'h0063
`define ID_WCMD_LO 16'h0064
`define ID_WCMD_HI 16'h0077
`define ID_DEFN_LO 16'h0078
`define ID_DEFN_HI 16'h00A0
`define ID_CONFIG 16'h00FF
`define UNCONF_MARK 16'h00FF

`define W_P1_BAUD 6'h01
`define W_P1_TMO 6'h02
`define W_P2_BAUD 6'h0B
`define W_P2_TMO 6'h0C
`define W_RD_CNT 6'h15
`define W_WR_CNT 6'h16
`define W_CMD_CNT 6'h17
`define W_ERR_PTR 6'h18
`define W_DEFN_CNT 6'h1B

`define MAX_RD_CNT 16'h0050
`define MAX_CMD_CNT 16'h0014
`define MAX_ERR_PTR 16'h0F0A
`define MAX_DEFN_CNT 16'h0028
`define BAUD_MAX_CODE 16'h0007
`define BAUD_CODE_19200 3'h6
`define BAUD_CODE_38400 3'h7
`define ERR_TBL_SPAN 16'h0083
`define CMDS_PER_BLOCK 7'h05
`define REG_WORDS 16'h0032

`define CLK_PERIOD_NS 25
`define MS_PERIOD_NS 1000000
`define TICK_CYCLES (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define TMO_DEFAULT_MS 16'h03E8

`endif

// [block_xfer_pkg.sv]
// Types shared by the block transfer decoder
package block_xfer_pkg;

  typedef enum logic [2:0] {
    BLK_NONE,
    BLK_POLL,
    BLK_WCMD,
    BLK_DEFN,
    BLK_CONFIG
  } blk_kind_e;

  typedef enum logic [0:0] {
    ST_WAIT_CFG,
    ST_RUN
  } mod_state_e;

  typedef struct packed {
    logic valid;
    blk_kind_e kind;
    logic [5:0] index;
    logic [6:0] first_cmd;
  } dispatch_s;

  typedef struct packed {
    logic [2:0] baud1;
    logic [2:0] baud2;
    logic [15:0] baud1_rate;
    logic [15:0] baud2_rate;
    logic [15:0] tmo1_ms;
    logic [15:0] tmo2_ms;
    logic [15:0] rd_cnt;
    logic [15:0] wr_cnt;
    logic [15:0] cmd_cnt;
    logic [15:0] err_ptr;
    logic [15:0] err_end;
    logic [15:0] defn_cnt;
  } config_s;

endpackage

// [block_xfer_decoder.sv]
// Host write block decoder and module configuration handler
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "block_xfer_map.svh"

module block_xfer_decoder
  import block_xfer_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [5:0] payload_adr_i,
  output logic [15:0] payload_dat_o,
  output dispatch_s dispatch_o,
  output config_s cfg_o,
  output logic configured_o,
  output logic port_cfg_err_o,
  output logic sys_cfg_err_o,
  output logic clear_lists_o,
  output logic start_poll_o,
  output logic cmd_list_req_o,
  output logic [15:0] defn_req_cnt_o,
  input wire logic [1:0] cmd_sent_i,
  input wire logic [1:0] reply_i,
  output logic [1:0] retransmit_o
);

  logic [15:0] wbuf_ff [0:63];
  logic submit_ff;
  mod_state_e state_ff;
  logic poll_held_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  dispatch_s disp_ff;
  config_s cfg_ff;
  logic port_err_ff;
  logic sys_err_ff;
  logic clear_ff;
  logic start_poll_ff;
  logic cmd_req_ff;
  logic [15:0] payload_ff;
  logic [15:0] tick_cnt_ff;
  logic tick_ff;
  logic [1:0] armed_ff;
  logic [15:0] ms_cnt_ff [0:1];
  logic [1:0] retx_ff;

  logic wb_req;
  logic [15:0] blk_id;
  blk_kind_e kind;
  logic [15:0] nxt_tmo1;
  logic [15:0] nxt_tmo2;
  logic port_bad;
  logic sys_bad;
  logic cfg_ok;

  function automatic blk_kind_e decode_id(input logic [15:0] id);
    if (id >= `ID_POLL_LO && id <= `ID_POLL_HI) begin
      decode_id = BLK_POLL;
    end else if (id >= `ID_WCMD_LO && id <= `ID_WCMD_HI) begin
      decode_id = BLK_WCMD;
    end else if (id >= `ID_DEFN_LO && id <= `ID_DEFN_HI) begin
      decode_id = BLK_DEFN;
    end else if (id == `ID_CONFIG) begin
      decode_id = BLK_CONFIG;
    end else begin
      decode_id = BLK_NONE;
    end
  endfunction

  function automatic logic [15:0] baud_rate(input logic [2:0] code);
    case (code)
      3'h0: baud_rate = 16'h012C;
      3'h1: baud_rate = 16'h0258;
      3'h2: baud_rate = 16'h04B0;
      3'h3: baud_rate = 16'h0960;
      3'h4: baud_rate = 16'h12C0;
      3'h5: baud_rate = 16'h2580;
      3'h6: baud_rate = 16'h4B00;
      default: baud_rate = 16'h9600;
    endcase
  endfunction

  function automatic logic [15:0] tmo_or_default(input logic [15:0] v);
    tmo_or_default = (v == 16'h0000) ? `TMO_DEFAULT_MS : v;
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_ff;
  assign blk_id = wbuf_ff[0];
  assign kind = decode_id(blk_id);
  assign nxt_tmo1 = tmo_or_default(wbuf_ff[`W_P1_TMO]);
  assign nxt_tmo2 = tmo_or_default(wbuf_ff[`W_P2_TMO]);

  // Out-of-range codes are refused too, so a port never runs at an unknown rate
  assign port_bad = (wbuf_ff[`W_P1_BAUD] > `BAUD_MAX_CODE) || (wbuf_ff[`W_P2_BAUD] > `BAUD_MAX_CODE)
    || (wbuf_ff[`W_P1_BAUD][2:0] == `BAUD_CODE_19200 && wbuf_ff[`W_P2_BAUD][2:0] == `BAUD_CODE_38400)
    || (wbuf_ff[`W_P1_BAUD][2:0] == `BAUD_CODE_38400 && wbuf_ff[`W_P2_BAUD][2:0] == `BAUD_CODE_19200);
  assign sys_bad = (wbuf_ff[`W_RD_CNT] > `MAX_RD_CNT)
    || (wbuf_ff[`W_CMD_CNT] > `MAX_CMD_CNT)
    || (wbuf_ff[`W_ERR_PTR] > `MAX_ERR_PTR)
    || (wbuf_ff[`W_DEFN_CNT] > `MAX_DEFN_CNT);
  assign cfg_ok = !port_bad && !sys_bad;

  // Write buffer fill; the host stages a whole block before committing it
  always_ff @(posedge clk_i) begin
    if (wb_req && we_i && adr_i <= `WBUF_LAST && adr_i[1:0] == 2'h0) begin
      if (sel_i[0]) begin
        wbuf_ff[adr_i[7:2]][7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        wbuf_ff[adr_i[7:2]][15:8] <= dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      submit_ff <= 1'b0;
    end else begin
      submit_ff <= wb_req && we_i && adr_i == `CTRL_ADDR;
    end
  end

  // Bus answer: one registered ack per request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          `STATUS_ADDR: dat_ff <= {28'h0000000, poll_held_ff, sys_err_ff, port_err_ff, state_ff == ST_RUN};
          `RDHDR_ADDR: dat_ff <= {16'h0000, (state_ff == ST_RUN) ? 16'h0000 : `UNCONF_MARK};
          `CFGA_ADDR: dat_ff <= {cfg_ff.rd_cnt, cfg_ff.err_ptr};
          `CFGB_ADDR: dat_ff <= {cfg_ff.cmd_cnt, cfg_ff.defn_cnt};
          default: begin
            if (adr_i <= `WBUF_LAST) begin
              dat_ff <= {16'h0000, wbuf_ff[adr_i[7:2]]};
            end else begin
              dat_ff <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  // Waiting loop versus running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_WAIT_CFG;
    end else if (submit_ff && kind == BLK_CONFIG) begin
      state_ff <= cfg_ok ? ST_RUN : ST_WAIT_CFG;
    end
  end

  // Error flags re-evaluated on every config block; configuration captured only when the block passes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= '0;
      port_err_ff <= 1'b0;
      sys_err_ff <= 1'b0;
    end else if (submit_ff && kind == BLK_CONFIG) begin
      port_err_ff <= port_bad;
      sys_err_ff <= sys_bad;
      if (cfg_ok) begin
        cfg_ff.baud1 <= wbuf_ff[`W_P1_BAUD][2:0];
        cfg_ff.baud2 <= wbuf_ff[`W_P2_BAUD][2:0];
        cfg_ff.baud1_rate <= baud_rate(wbuf_ff[`W_P1_BAUD][2:0]);
        cfg_ff.baud2_rate <= baud_rate(wbuf_ff[`W_P2_BAUD][2:0]);
        cfg_ff.tmo1_ms <= nxt_tmo1;
        cfg_ff.tmo2_ms <= nxt_tmo2;
        cfg_ff.rd_cnt <= wbuf_ff[`W_RD_CNT];
        cfg_ff.wr_cnt <= wbuf_ff[`W_WR_CNT];
        cfg_ff.cmd_cnt <= wbuf_ff[`W_CMD_CNT];
        cfg_ff.err_ptr <= wbuf_ff[`W_ERR_PTR];
        cfg_ff.err_end <= wbuf_ff[`W_ERR_PTR] + `ERR_TBL_SPAN - 16'h0001;
        cfg_ff.defn_cnt <= wbuf_ff[`W_DEFN_CNT];
      end
    end
  end

  // Any config block behaves like a power cycle for the held lists
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_ff <= 1'b0;
      poll_held_ff <= 1'b0;
    end else begin
      clear_ff <= submit_ff && kind == BLK_CONFIG;
      if (submit_ff && kind == BLK_CONFIG) begin
        poll_held_ff <= 1'b0;
      end else if (submit_ff && kind == BLK_POLL && state_ff == ST_RUN) begin
        poll_held_ff <= 1'b1;
      end
    end
  end

  // Start-up choice after a good configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_poll_ff <= 1'b0;
      cmd_req_ff <= 1'b0;
    end else begin
      start_poll_ff <= submit_ff && kind == BLK_CONFIG && cfg_ok && poll_held_ff;
      cmd_req_ff <= submit_ff && kind == BLK_CONFIG && cfg_ok && !poll_held_ff;
    end
  end

  // Dispatch of payload blocks, only once configured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_ff <= '0;
    end else begin
      disp_ff.valid <= submit_ff && state_ff == ST_RUN
        && (kind == BLK_POLL || kind == BLK_WCMD || kind == BLK_DEFN);
      disp_ff.kind <= kind;
      case (kind)
        BLK_POLL: disp_ff.index <= 6'(blk_id - `ID_POLL_LO);
        BLK_WCMD: disp_ff.index <= 6'(blk_id - `ID_WCMD_LO);
        BLK_DEFN: disp_ff.index <= 6'(blk_id - `ID_DEFN_LO);
        default: disp_ff.index <= 6'h00;
      endcase
      disp_ff.first_cmd <= 7'(blk_id - `ID_POLL_LO) * `CMDS_PER_BLOCK + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      payload_ff <= 16'h0000;
    end else begin
      payload_ff <= wbuf_ff[payload_adr_i];
    end
  end

  // 1 ms enable from the 40 MHz clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // Response timers; first ms may be short by up to one tick period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_ff <= 2'b00;
      retx_ff <= 2'b00;
      ms_cnt_ff[0] <= 16'h0000;
      ms_cnt_ff[1] <= 16'h0000;
    end else begin
      for (int p = 0; p < 2; p++) begin
        retx_ff[p] <= 1'b0;
        if (reply_i[p] || state_ff != ST_RUN) begin
          armed_ff[p] <= 1'b0;
        end else if (cmd_sent_i[p]) begin
          armed_ff[p] <= 1'b1;
          ms_cnt_ff[p] <= 16'h0000;
        end else if (armed_ff[p] && tick_ff) begin
          if (ms_cnt_ff[p] + 16'h0001 >= ((p == 0) ? cfg_ff.tmo1_ms : cfg_ff.tmo2_ms)) begin
            retx_ff[p] <= 1'b1;
            armed_ff[p] <= 1'b0;
          end else begin
            ms_cnt_ff[p] <= ms_cnt_ff[p] + 16'h0001;
          end
        end
      end
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign payload_dat_o = payload_ff;
  assign dispatch_o = disp_ff;
  assign cfg_o = cfg_ff;
  assign configured_o = state_ff == ST_RUN;
  assign port_cfg_err_o = port_err_ff;
  assign sys_cfg_err_o = sys_err_ff;
  assign clear_lists_o = clear_ff;
  assign start_poll_o = start_poll_ff;
  assign cmd_list_req_o = cmd_req_ff;
  assign defn_req_cnt_o = cfg_ff.defn_cnt;
  assign retransmit_o = retx_ff;

  sequence s_config_commit;
    submit_ff && kind == BLK_CONFIG;
  endsequence

  sequence s_rdhdr_read;
    wb_req && !we_i && adr_i == `RDHDR_ADDR;
  endsequence

  a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req |=> ack_o ##1 !ack_o) else $error("ack not a single pulse");
  a_unconf_mark_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rdhdr_read and !configured_o |=> dat_o[15:0] == 16'h00FF) else $error("unconfigured mark missing");
  a_clear_on_config: assert property (@(posedge clk_i) disable iff (rst_i)
    s_config_commit |=> clear_lists_o && !poll_held_ff) else $error("config did not clear lists");
  a_no_disp_unconf: assert property (@(posedge clk_i) disable iff (rst_i)
    dispatch_o.valid |-> $past(configured_o)) else $error("dispatch while unconfigured");
  a_invalid_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
    submit_ff && kind == BLK_NONE |=> !dispatch_o.valid && !clear_lists_o && $stable(configured_o))
    else $error("invalid block changed state");
  a_baud_clash_err: assert property (@(posedge clk_i) disable iff (rst_i)
    s_config_commit ##0 (wbuf_ff[`W_P1_BAUD] == 16'h0006 && wbuf_ff[`W_P2_BAUD] == 16'h0007)
    |=> port_cfg_err_o && !configured_o) else $error("baud clash accepted");
  a_read_cnt_err: assert property (@(posedge clk_i) disable iff (rst_i)
    s_config_commit ##0 wbuf_ff[`W_RD_CNT] > 16'h0050 |=> sys_cfg_err_o) else $error("read count not checked");
  a_startup_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(configured_o) |-> start_poll_o ^ cmd_list_req_o) else $error("no start action on configuration");
  a_poll_cmd_index: assert property (@(posedge clk_i) disable iff (rst_i)
    dispatch_o.valid && dispatch_o.kind == BLK_POLL |-> dispatch_o.index < 6'd20
    && dispatch_o.first_cmd == 7'(dispatch_o.index) * 7'd5 + 7'd1) else $error("poll block index wrong");

endmodule

// [host_bus_model.sv]
// Host controller model writing whole 64-word blocks over classic Wishbone
`timescale 1ns/1ps
`include "block_xfer_map.svh"
module host_bus_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [11:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  logic [15:0] blk [64];

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 12'h000;
    sel_o = 4'h0;
    wdat_o = 32'h00000000;
  end

  // Request held until ack is sampled; released data is inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    wdat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    wdat_o <= ~d;
  endtask

  // Always the full 64 words, identifier first, then the commit
  task automatic send_block;
    logic [31:0] q;
    for (int i = 0; i < 64; i++) xfer(1'b1, 12'(i * 4), {16'h0000, blk[i]}, q);
    xfer(1'b1, `CTRL_ADDR, 32'h00000000, q);
  endtask
endmodule

// [block_transfer_config_decoder_tb.sv]
// Self-checking bench for the block transfer configuration decoder
`timescale 1ns/1ps
`include "block_xfer_map.svh"
module block_transfer_config_decoder_tb;
  import block_xfer_pkg::*;
  localparam int TICK = 8;
  logic clk_i, rst_i, cyc, stb, we, ack_o, configured_o, port_cfg_err_o, sys_cfg_err_o;
  logic clear_lists_o, start_poll_o, cmd_list_req_o;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o;
  logic [5:0] payload_adr_i;
  logic [15:0] payload_dat_o, defn_req_cnt_o;
  logic [1:0] cmd_sent_i, reply_i, retransmit_o;
  dispatch_s dispatch_o, last_d;
  config_s cfg_o;
  int err_total = 0, samples_checked = 0, cyc_n = 0, n_clr = 0, n_run = 0, n_disp = 0, n_sp = 0;
  int n_rt [2] = '{0, 0};
  int rt_at [2] = '{0, 0};

  block_xfer_decoder #(.TICK_CYCLES(TICK)) u_block_xfer_decoder (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o, .ack_o, .payload_adr_i, .payload_dat_o,
    .dispatch_o, .cfg_o, .configured_o, .port_cfg_err_o, .sys_cfg_err_o, .clear_lists_o, .start_poll_o,
    .cmd_list_req_o, .defn_req_cnt_o, .cmd_sent_i, .reply_i, .retransmit_o);
  host_bus_model u_host_bus_model (.clk_i, .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Pulse outputs last one cycle, so they are counted rather than polled
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (clear_lists_o === 1'b1) n_clr <= n_clr + 1;
    if ((start_poll_o ^ cmd_list_req_o) === 1'b1) n_run <= n_run + 1;
    if (start_poll_o === 1'b1) n_sp <= n_sp + 1;
    if (dispatch_o.valid === 1'b1) begin
      n_disp <= n_disp + 1;
      last_d <= dispatch_o;
    end
    for (int p = 0; p < 2; p++) begin
      if (retransmit_o[p] === 1'b1) begin
        n_rt[p] <= n_rt[p] + 1;
        rt_at[p] <= cyc_n;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    u_host_bus_model.xfer(1'b0, a, 32'h00000000, q);
  endtask

  task automatic fill(input logic [15:0] id);
    for (int i = 0; i < 64; i++) u_host_bus_model.blk[i] = 16'(i);
    u_host_bus_model.blk[0] = id;
  endtask

  task automatic go;
    u_host_bus_model.send_block();
    repeat (3) @(posedge clk_i);
  endtask

  task automatic cfg(input logic [15:0] b1, t1, b2, t2, rc, cc, ep, dc);
    fill(`ID_CONFIG);
    for (int i = 1; i < 64; i++) u_host_bus_model.blk[i] = 16'h0000;
    u_host_bus_model.blk[1] = b1;
    u_host_bus_model.blk[2] = t1;
    u_host_bus_model.blk[11] = b2;
    u_host_bus_model.blk[12] = t2;
    u_host_bus_model.blk[21] = rc;
    u_host_bus_model.blk[22] = 16'h0004;
    u_host_bus_model.blk[23] = cc;
    u_host_bus_model.blk[24] = ep;
    u_host_bus_model.blk[27] = dc;
    go();
  endtask

  task automatic pulse(input logic [1:0] c, input logic [1:0] r);
    @(posedge clk_i);
    cmd_sent_i <= c;
    reply_i <= r;
    @(posedge clk_i);
    cmd_sent_i <= 2'b00;
    reply_i <= 2'b00;
  endtask

  task automatic t_boot;
    logic [31:0] q;
    rd(`STATUS_ADDR, q);
    chk("status", 32'h0, q);
    rd(`RDHDR_ADDR, q);
    chk("rd_word1", 32'h00FF, q);
    rd(12'h200, q);
    chk("unmapped", 32'h0, q);
    $display("boot done");
  endtask

  task automatic t_unconf;
    logic [31:0] q;
    int d0 = n_disp;
    fill(16'h0050);
    go();
    chk("disp_cnt", 32'h0, 32'(n_disp - d0));
    chk("configured", 32'h0, 32'(configured_o));
    rd(`RDHDR_ADDR, q);
    chk("rd_word1", 32'h00FF, q);
    $display("unconfigured done");
  endtask

  task automatic t_baud;
    logic [15:0] rate [8] = '{16'h012C, 16'h0258, 16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00, 16'h9600};
    logic [31:0] q;
    int c0, r0;
    for (int b = 0; b < 8; b++) begin
      c0 = n_clr;
      r0 = n_run;
      cfg(16'(b), 16'h0005, 16'h0005, 16'h000A, 16'h0005, 16'h0002, 16'h0064, 16'h0003);
      chk("configured", 32'h1, 32'(configured_o));
      chk("cleared", 32'h1, 32'(n_clr - c0));
      chk("run_start", 32'h1, 32'(n_run - r0));
      chk("rate1", 32'(rate[b]), 32'(cfg_o.baud1_rate));
      chk("tmo", 32'h0005000A, {cfg_o.tmo1_ms, cfg_o.tmo2_ms});
      chk("baud2", 32'h5, 32'(cfg_o.baud2));
      chk("counts", 32'h00050002, {cfg_o.rd_cnt, cfg_o.cmd_cnt});
      chk("err_end", 32'h00E6, 32'(cfg_o.err_end));
      chk("defn_req", 32'h3, 32'(defn_req_cnt_o));
      rd(`CFGA_ADDR, q);
      chk("cfga", 32'h00050064, q);
      rd(`CFGB_ADDR, q);
      chk("cfgb", 32'h00020003, q);
      chk("wr_cnt", 32'h4, 32'(cfg_o.wr_cnt));
      rd(`RDHDR_ADDR, q);
      chk("rd_word1", 32'h0, q);
    end
    rd(12'h06C, q);
    chk("staged", 32'h3, q);
    payload_adr_i <= `W_DEFN_CNT;
    repeat (2) @(posedge clk_i);
    chk("payload", 32'h3, 32'(payload_dat_o));
    $display("baud done");
  endtask

  task automatic t_dispatch;
    logic [15:0] ids [10] = '{16'h0050, 16'h0063, 16'h0064, 16'h0077, 16'h0078, 16'h00A0,
                              16'h004F, 16'h00A1, 16'h00FE, 16'h01FF};
    logic [31:0] q;
    int d0;
    blk_kind_e k;
    logic [15:0] base;
    for (int j = 0; j < 10; j++) begin
      d0 = n_disp;
      fill(ids[j]);
      go();
      chk("disp_cnt", 32'(j < 6), 32'(n_disp - d0));
      if (j < 6) begin
        k = ids[j] < 16'h0064 ? BLK_POLL : ids[j] < 16'h0078 ? BLK_WCMD : BLK_DEFN;
        base = k == BLK_POLL ? 16'h0050 : k == BLK_WCMD ? 16'h0064 : 16'h0078;
        chk("kind", 32'(k), 32'(last_d.kind));
        chk("index", 32'(ids[j] - base), 32'(last_d.index));
        if (k == BLK_POLL) chk("first_cmd", 32'((ids[j] - base) * 5 + 1), 32'(last_d.first_cmd));
      end
    end
    chk("configured", 32'h1, 32'(configured_o));
    rd(`STATUS_ADDR, q);
    chk("poll_held", 32'h1, 32'(q[`STAT_POLL_HELD]));
    $display("dispatch done");
  endtask

  task automatic t_limits;
    logic [15:0] b1, b2, rc, cc, ep, dc;
    logic [31:0] q;
    int c0, s0;
    for (int k = 0; k < 8; k++) begin
      b1 = 16'h0005;
      b2 = 16'h0005;
      rc = `MAX_RD_CNT;
      cc = `MAX_CMD_CNT;
      ep = `MAX_ERR_PTR;
      dc = `MAX_DEFN_CNT;
      case (k)
        1: begin
          b1 = 16'h0006;
          b2 = 16'h0007;
        end
        2: begin
          b1 = 16'h0007;
          b2 = 16'h0006;
        end
        3: rc = rc + 16'h0001;
        4: cc = cc + 16'h0001;
        5: ep = ep + 16'h0001;
        6: dc = dc + 16'h0001;
        7: b1 = 16'h0008;
        default: ;
      endcase
      c0 = n_clr;
      s0 = n_sp;
      cfg(b1, 16'h0005, b2, 16'h0005, rc, cc, ep, dc);
      chk("port_err", 32'(k == 1 || k == 2 || k == 7), 32'(port_cfg_err_o));
      chk("sys_err", 32'(k > 2 && k < 7), 32'(sys_cfg_err_o));
      chk("start_poll", 32'(k == 0), 32'(n_sp - s0));
      chk("configured", 32'(k == 0), 32'(configured_o));
      chk("cleared", 32'h1, 32'(n_clr - c0));
      rd(`STATUS_ADDR, q);
      chk("poll_held", 32'h0, 32'(q[`STAT_POLL_HELD]));
    end
    $display("limits done");
  endtask

  task automatic t_timeout;
    int t0, r0;
    cfg(16'h0005, 16'h0002, 16'h0005, 16'h0000, 16'h0005, 16'h0002, 16'h0064, 16'h0003);
    chk("tmo_default", 32'h03E8, 32'(cfg_o.tmo2_ms));
    pulse(2'b01, 2'b00);
    t0 = cyc_n;
    r0 = n_rt[0];
    for (int w = 0; w < 100 && n_rt[0] == r0; w++) @(posedge clk_i);
    chk("rt_port1", 32'h1, 32'(rt_at[0] - t0 >= TICK && rt_at[0] - t0 <= 2 * TICK + 4));
    pulse(2'b01, 2'b00);
    repeat (3) @(posedge clk_i);
    pulse(2'b00, 2'b01);
    r0 = n_rt[0];
    repeat (40) @(posedge clk_i);
    chk("rt_after_reply", 32'h0, 32'(n_rt[0] - r0));
    pulse(2'b10, 2'b00);
    t0 = cyc_n;
    r0 = n_rt[1];
    for (int w = 0; w < 9000 && n_rt[1] == r0; w++) @(posedge clk_i);
    chk("rt_port2", 32'h1, 32'(rt_at[1] - t0 >= 999 * TICK && rt_at[1] - t0 <= 1000 * TICK + 4));
    $display("timeout done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    cmd_sent_i = 2'b00;
    reply_i = 2'b00;
    payload_adr_i = 6'h00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_unconf();
    t_baud();
    t_dispatch();
    t_limits();
    t_timeout();
    end_sim();
  end
endmodule
